// file: verilog/cctm_map.vh
`ifndef CCTM_MAP_VH
`define CCTM_MAP_VH

// register byte offsets
`define CCTM_OFS_SLOT0 8'h00
`define CCTM_OFS_CTRL 8'h20
`define CCTM_OFS_MEN1 8'h24
`define CCTM_OFS_MEN2 8'h28
`define CCTM_OFS_DBC1 8'h2C
`define CCTM_OFS_DBC2 8'h30
`define CCTM_OFS_MAT1 8'h34
`define CCTM_OFS_MAT2 8'h38
`define CCTM_OFS_CHG1 8'h3C
`define CCTM_OFS_CHG2 8'h40
`define CCTM_OFS_STAT 8'h44

// control and status fields
`define CCTM_CTRL_DB_EN 0
`define CCTM_CTRL_SINK 1
`define CCTM_CTRL_VENDOR 2
`define CCTM_STAT_VALID 0

// threshold slot reset levels, millivolts
`define CCTM_RST_SLOT0 16'h00C8
`define CCTM_RST_SLOT1 16'h0190
`define CCTM_RST_SLOT2 16'h0294
`define CCTM_RST_SLOT3 16'h0320
`define CCTM_RST_SLOT4 16'h04CE
`define CCTM_RST_SLOT5 16'h0640
`define CCTM_RST_SLOT6 16'h0A28
`define CCTM_RST_SLOT7 16'h0BB8

`define CCTM_RST_MASK 8'h00
`define CCTM_VENDOR_SLOT 7
`define CCTM_DEB_CYCLES 16

`endif

// file: verilog/cctm_threshold_match.v
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "cctm_map.vh"

// Summary of operation
// RULE1: eight threshold slots per pin, one bit each
// RULE2: slots reset to rising levels, seven vendor
// RULE3: sink role reports advertised level changes
// RULE4: source with powered cable reads zero
// RULE5: source with sink: single level bit set
// RULE6: source open pin: level bit plus open bit
// RULE7: vendor mode open pin: only bit seven
// RULE8: sink role cable or open reads zero
// RULE9: sink role bits accumulate with level
// RULE10: software writes 0x22 to both masks
// RULE11: software writes 0x15 to both masks
// RULE12: debounced match sets match and change bits
// RULE13: higher enabled match sets lower enabled bits
// RULE14: valid flag after both pins first debounce
// RULE15: enable gates raw; change bits sticky
// RULE16: follow slot positions, not printed mask
module cctm_threshold_match #(
	parameter DEB_CYCLES = `CCTM_DEB_CYCLES
) (
	input wire clock_i,
	input wire reset_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [7:0] paddr_i,
	input wire [31:0] pwdata_i,
	output reg [31:0] prdata_o,
	output reg pready_o,
	output reg pslverr_o,
	input wire [7:0] cc1_raw_i,
	input wire [7:0] cc2_raw_i,
	output reg [127:0] slot_levels_o,
	output reg match_valid_flag_o
);

	// last value of a pin's debounce count; the count rests there
	localparam [31:0] CNT_LAST = DEB_CYCLES - 1;

	reg [15:0] slot_q [0:7];
	reg [2:0] ctrl_q;
	reg [15:0] men_q;
	reg [15:0] dbc_q;
	reg [15:0] match_q;
	reg [15:0] chg_q;
	reg [1:0] seen_q;
	reg [15:0] s1_q;
	reg [15:0] s2_q;
	reg [15:0] s3_q;
	reg [15:0] held_q;
	reg [15:0] cand_q;
	reg [31:0] cnt1_q;
	reg [31:0] cnt2_q;
	reg [31:0] rdata_d;
	reg err_d;
	reg [15:0] filt_d;
	reg [15:0] chg_set_d;
	reg [15:0] chg_clr_d;
	reg [15:0] commit_d;
	reg [1:0] restart_d;
	integer i;

	// slot registers fill the first eight aligned words
	function cctm_slot_hit;
		input [7:0] addr;
		begin
			cctm_slot_hit = (addr[7:5] == 3'h0) && (addr[1:0] == 2'h0);
		end
	endfunction

	// restart on a masked change, else count up and rest at the end
	function [31:0] cctm_count_next;
		input [31:0] cnt;
		input restart;
		begin
			if (restart) begin
				cctm_count_next = 32'h00000000;
			end else if (cnt != CNT_LAST) begin
				cctm_count_next = cnt + 32'h00000001;
			end else begin
				cctm_count_next = cnt;
			end
		end
	endfunction

	// gate, then extend down through the enabled slots; vendor mode keeps slot seven only
	function [7:0] cctm_fill;
		input [7:0] raw;
		input [7:0] en;
		input vend;
		reg [7:0] g;
		reg any;
		integer k;
		begin
			g = raw & en; // RULE15
			any = 1'h0;
			cctm_fill = 8'h00;
			if (vend) begin
				cctm_fill[`CCTM_VENDOR_SLOT] = g[`CCTM_VENDOR_SLOT]; // RULE7
			end else begin
				for (k = 7; k >= 0; k = k - 1) begin
					any = any | g[k];
					cctm_fill[k] = any & en[k]; // RULE13 RULE5 RULE6 RULE9
				end
			end
		end
	endfunction

	wire setup = psel_i & ~penable_i;
	wire acc = psel_i & penable_i & pready_o;
	wire wr = acc & pwrite_i;
	wire [7:0] a = paddr_i;
	wire slot_sel = cctm_slot_hit(a);
	wire src_vendor = ~ctrl_q[`CCTM_CTRL_SINK] & ctrl_q[`CCTM_CTRL_VENDOR];
	wire db_en = ctrl_q[`CCTM_CTRL_DB_EN];
	wire clr1 = wr & (a == `CCTM_OFS_CHG1);
	wire clr2 = wr & (a == `CCTM_OFS_CHG2);

	// source cable and sink cable or open cases read zero because the comparator sees no enabled level
	always @* begin
		filt_d[15:8] = cctm_fill(held_q[15:8], men_q[15:8], src_vendor); // RULE3
		filt_d[7:0] = cctm_fill(held_q[7:0], men_q[7:0], src_vendor); // RULE4 RULE8
		restart_d[0] = |((filt_d[7:0] ^ cand_q[7:0]) & dbc_q[7:0]);
		restart_d[1] = |((filt_d[15:8] ^ cand_q[15:8]) & dbc_q[15:8]);
		commit_d = 16'h0000;
		if (db_en && cnt1_q == CNT_LAST) begin
			commit_d[7:0] = 8'hFF;
		end
		if (db_en && cnt2_q == CNT_LAST) begin
			commit_d[15:8] = 8'hFF;
		end
		chg_set_d = (cand_q ^ match_q) & commit_d; // RULE15
		chg_clr_d = 16'h0000;
		if (clr1) begin
			chg_clr_d[7:0] = pwdata_i[7:0];
		end
		if (clr2) begin
			chg_clr_d[15:8] = pwdata_i[7:0];
		end
	end

	always @* begin
		rdata_d = 32'h00000000;
		err_d = 1'h0;
		if (slot_sel) begin
			rdata_d[15:0] = slot_q[a[4:2]];
		end else begin
			case (a)
			`CCTM_OFS_CTRL: rdata_d[2:0] = ctrl_q;
			`CCTM_OFS_MEN1: rdata_d[7:0] = men_q[7:0];
			`CCTM_OFS_MEN2: rdata_d[7:0] = men_q[15:8];
			`CCTM_OFS_DBC1: rdata_d[7:0] = dbc_q[7:0];
			`CCTM_OFS_DBC2: rdata_d[7:0] = dbc_q[15:8];
			`CCTM_OFS_MAT1: rdata_d[7:0] = match_q[7:0];
			`CCTM_OFS_MAT2: rdata_d[7:0] = match_q[15:8];
			`CCTM_OFS_CHG1: rdata_d[7:0] = chg_q[7:0];
			`CCTM_OFS_CHG2: rdata_d[7:0] = chg_q[15:8];
			`CCTM_OFS_STAT: rdata_d[`CCTM_STAT_VALID] = match_valid_flag_o;
			default: err_d = 1'h1;
			endcase
		end
	end

	// apb: answer is ready in the first access cycle, no wait states
	always @(posedge clock_i) begin
		if (reset_i) begin
			pready_o <= 1'h0;
			pslverr_o <= 1'h0;
		end else begin
			pready_o <= setup;
			pslverr_o <= setup & err_d;
		end
	end

	// read data stays zero outside a good read so stale words never leak
	always @(posedge clock_i) begin
		if (reset_i) begin
			prdata_o <= 32'h00000000;
		end else if (setup && !pwrite_i && !err_d) begin
			prdata_o <= rdata_d;
		end else begin
			prdata_o <= 32'h00000000;
		end
	end

	always @(posedge clock_i) begin
		if (reset_i) begin
			slot_q[0] <= `CCTM_RST_SLOT0; // RULE2
			slot_q[1] <= `CCTM_RST_SLOT1;
			slot_q[2] <= `CCTM_RST_SLOT2;
			slot_q[3] <= `CCTM_RST_SLOT3;
			slot_q[4] <= `CCTM_RST_SLOT4;
			slot_q[5] <= `CCTM_RST_SLOT5;
			slot_q[6] <= `CCTM_RST_SLOT6;
			slot_q[7] <= `CCTM_RST_SLOT7;
		end else if (wr && slot_sel) begin
			slot_q[a[4:2]] <= pwdata_i[15:0]; // RULE1
		end
	end

	always @(posedge clock_i) begin
		if (reset_i) begin
			ctrl_q <= 3'h0;
			men_q <= {`CCTM_RST_MASK, `CCTM_RST_MASK};
			dbc_q <= {`CCTM_RST_MASK, `CCTM_RST_MASK};
		end else if (wr) begin
			case (a)
			`CCTM_OFS_CTRL: ctrl_q <= pwdata_i[2:0];
			`CCTM_OFS_MEN1: men_q[7:0] <= pwdata_i[7:0]; // RULE16
			`CCTM_OFS_MEN2: men_q[15:8] <= pwdata_i[7:0];
			`CCTM_OFS_DBC1: dbc_q[7:0] <= pwdata_i[7:0];
			`CCTM_OFS_DBC2: dbc_q[15:8] <= pwdata_i[7:0];
			default: ;
			endcase
		end
	end

	always @(posedge clock_i) begin
		for (i = 0; i < 8; i = i + 1) begin
			slot_levels_o[i*16 +: 16] <= slot_q[i];
		end
	end

	// three-stage sync; only stage two reads stage one
	always @(posedge clock_i) begin
		if (reset_i) begin
			s1_q <= 16'h0000;
			s2_q <= 16'h0000;
			s3_q <= 16'h0000;
		end else begin
			s1_q <= {cc2_raw_i, cc1_raw_i};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// a bit moves once stages two and three agree
	always @(posedge clock_i) begin
		if (reset_i) begin
			held_q <= 16'h0000;
		end else begin
			held_q <= (s2_q & ~(s2_q ^ s3_q)) | (held_q & (s2_q ^ s3_q));
		end
	end

	always @(posedge clock_i) begin
		if (reset_i || !db_en) begin
			cand_q <= 16'h0000;
		end else begin
			cand_q <= filt_d;
		end
	end

	// a change in a debounce-clear bit restarts that pin's interval
	always @(posedge clock_i) begin
		if (reset_i || !db_en) begin
			cnt1_q <= 32'h00000000;
		end else begin
			cnt1_q <= cctm_count_next(cnt1_q, restart_d[0]);
		end
	end

	always @(posedge clock_i) begin
		if (reset_i || !db_en) begin
			cnt2_q <= 32'h00000000;
		end else begin
			cnt2_q <= cctm_count_next(cnt2_q, restart_d[1]);
		end
	end

	always @(posedge clock_i) begin
		if (reset_i) begin
			match_q <= 16'h0000;
		end else begin
			match_q <= (cand_q & commit_d) | (match_q & ~commit_d); // RULE12
		end
	end

	// set wins over the write-one clear, on each pin independently
	always @(posedge clock_i) begin
		if (reset_i) begin
			chg_q <= 16'h0000;
		end else begin
			chg_q <= (chg_q & ~chg_clr_d) | chg_set_d; // RULE12 RULE15
		end
	end

	// valid waits for the first commit of both pins after the debouncer starts
	always @(posedge clock_i) begin
		if (reset_i || !db_en) begin
			seen_q <= 2'h0;
			match_valid_flag_o <= 1'h0;
		end else begin
			seen_q <= seen_q | {commit_d[8], commit_d[0]};
			match_valid_flag_o <= &(seen_q | {commit_d[8], commit_d[0]}); // RULE14
		end
	end

endmodule // cctm_threshold_match

// file: tb/cctm_monitor.sv
`timescale 1ns/1ps
`include "cctm_map.vh"
module cctm_monitor #(
	parameter DEB_CYCLES = 16
) (
	input wire clock_i,
	input wire reset_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [7:0] paddr_i,
	input wire [31:0] prdata_o,
	input wire pready_o,
	input wire pslverr_o,
	input wire [127:0] slot_levels_o,
	input wire match_valid_flag_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);
	chk_ready_first: assert property (psel_i && penable_i && !$past(penable_i) |-> pready_o) else $error("no ready");
	chk_ready_idle: assert property (!(psel_i && penable_i) |-> !pready_o) else $error("stray ready");
	chk_err_ready: assert property (pslverr_o |-> pready_o) else $error("stray error");
	chk_data_idle: assert property (!pready_o |-> prdata_o == 32'h0) else $error("stray data");
	chk_err_unmapped: assert property (pready_o && paddr_i > 8'h44 |-> pslverr_o) else $error("no error");
	chk_slot_reset: assert property ($fell(reset_i) |->
		slot_levels_o[127:112] == `CCTM_RST_SLOT7) else $error("slot reset");
	chk_match_upper: assert property (pready_o && !pwrite_i && paddr_i == 8'h34 |->
		prdata_o[31:8] == 24'h0) else $error("match width");
	chk_valid_late: assert property ($rose(match_valid_flag_o) |-> !$past(reset_i, 4)) else $error("early valid");
endmodule // cctm_monitor
bind cctm_threshold_match cctm_monitor #(.DEB_CYCLES(DEB_CYCLES)) mon (.clock_i(clock_i), .reset_i(reset_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
	.pready_o(pready_o), .pslverr_o(pslverr_o), .slot_levels_o(slot_levels_o),
	.match_valid_flag_o(match_valid_flag_o));

// file: tb/cctm_cc_partner.sv
`timescale 1ns/1ps
module cctm_cc_partner (
	input wire clock_i,
	input wire [127:0] slot_levels_i,
	input wire [15:0] pin1_mv_i,
	input wire [15:0] pin2_mv_i,
	output reg [7:0] pin1_raw_o = 8'h00,
	output reg [7:0] pin2_raw_o = 8'h00
);
	integer n;
	// each comparator weighs the pin voltage against its slot's dac level
	always @(posedge clock_i) begin
		for (n = 0; n < 8; n = n + 1) begin
			pin1_raw_o[n] <= pin1_mv_i > slot_levels_i[16*n +: 16];
			pin2_raw_o[n] <= pin2_mv_i > slot_levels_i[16*n +: 16];
		end
	end
endmodule // cctm_cc_partner

// file: tb/test_cc_threshold_match.sv
`timescale 1ns/1ps
`include "cctm_map.vh"
module test_cc_threshold_match;
	reg clock_i = 0, reset_i = 1, psel = 0, penable = 0, pwrite = 0, err;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h0, q;
	reg [15:0] mv = 16'h0;
	wire [31:0] prdata;
	wire pready, perr, valid;
	wire [7:0] raw1, raw2;
	wire [127:0] lv;
	integer bad_count = 0, comparisons = 0, ticks = 0;
	cctm_threshold_match #(.DEB_CYCLES(4)) dut (.clock_i(clock_i), .reset_i(reset_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(perr), .cc1_raw_i(raw1), .cc2_raw_i(raw2), .slot_levels_o(lv),
		.match_valid_flag_o(valid));
	cctm_cc_partner cable (.clock_i(clock_i), .slot_levels_i(lv), .pin1_mv_i(mv), .pin2_mv_i(mv),
		.pin1_raw_o(raw1), .pin2_raw_o(raw2));
	initial forever #5 clock_i = ~clock_i;
	task give_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clock_i) begin
		ticks = ticks + 1;
		if (ticks == 3000) begin
			bad_count = bad_count + 1;
			give_verdict;
		end
	end
	task cmp(input [31:0] x, input [31:0] s, input string nm);
		comparisons = comparisons + 1;
		if (s !== x) begin
			bad_count = bad_count + 1;
			$display("mismatch %s expected %h seen %h", nm, x, s);
		end
	endtask
	task xfer(input w, input [7:0] a, input [31:0] d);
		@(posedge clock_i);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_i);
		penable <= 1;
		@(posedge clock_i);
		while (pready !== 1'b1) @(posedge clock_i);
		q = prdata;
		err = perr;
		psel <= 0;
		penable <= 0;
	endtask
	// control, then both pins' match and debounce-clear masks, then the cable level
	task step(input [31:0] c, input [31:0] m, input [15:0] v, input [31:0] x);
		reg [7:0] a;
		xfer(1'b1, 8'h20, c);
		for (a = 8'h24; a < 8'h34; a = a + 8'h04) xfer(1'b1, a, m);
		mv <= v;
		repeat (20) @(posedge clock_i);
		xfer(1'b0, 8'h34, 32'h0);
		cmp(x, q, "match1");
		xfer(1'b0, 8'h38, 32'h0);
		cmp(x, q, "match2");
	endtask
	task t_regs;
		xfer(1'b0, 8'h00, 32'h0);
		cmp(`CCTM_RST_SLOT0, q, "slot0");
		xfer(1'b0, 8'h1C, 32'h0);
		cmp(`CCTM_RST_SLOT7, q, "slot7");
		xfer(1'b0, 8'h48, 32'h0);
		cmp(32'h1, {31'h0, err}, "unmapped");
		cmp(32'h0, {31'h0, valid}, "valid idle");
		$display("test regs done");
	endtask
	task t_source;
		step(32'h1, 32'h22, 16'h012C, 32'h00);
		step(32'h1, 32'h22, 16'h03E8, 32'h02);
		cmp(32'h1, {31'h0, valid}, "valid");
		xfer(1'b0, 8'h44, 32'h0);
		cmp(32'h1, q, "status");
		step(32'h1, 32'h22, 16'h07D0, 32'h22);
		step(32'h1, 32'h21, 16'h03E8, 32'h01);
		step(32'h1, 32'h48, 16'h03E8, 32'h08);
		xfer(1'b1, 8'h3C, 32'hFF);
		step(32'h1, 32'h48, 16'h0AF0, 32'h48);
		xfer(1'b0, 8'h3C, 32'h0);
		cmp(32'h40, q, "change1");
		step(32'h5, 32'hFF, 16'h0C1C, 32'h80);
		$display("test source done");
	endtask
	task t_sink;
		step(32'h3, 32'h15, 16'h0064, 32'h00);
		xfer(1'b1, 8'h40, 32'hFF);
		step(32'h3, 32'h15, 16'h02BC, 32'h05);
		xfer(1'b0, 8'h40, 32'h0);
		cmp(32'h05, q, "change2");
		step(32'h3, 32'h95, 16'h0C1C, 32'h95);
		xfer(1'b1, 8'h08, 32'h0FFF);
		step(32'h3, 32'h15, 16'h05DC, 32'h15);
		xfer(1'b1, 8'h20, 32'h0);
		repeat (2) @(posedge clock_i);
		cmp(32'h0, {31'h0, valid}, "valid off");
		$display("test sink done");
	endtask
	initial begin
		repeat (20) @(posedge clock_i);
		reset_i <= 0;
		t_regs;
		t_source;
		t_sink;
		give_verdict;
	end
endmodule // test_cc_threshold_match
